// ---- include/hrsp_consts.svh ----
`ifndef HRSP_CONSTS_SVH
`define HRSP_CONSTS_SVH

// Slave addresses, upper six bits; the low bit comes from a factory input
`define HRSP_GEN_ADR_HI    6'h16
`define HRSP_VS_ADR_HI     6'h09
// High-speed master code, upper five bits
`define HRSP_HS_CODE       5'h01
// Read value for unreachable registers
`define HRSP_UNIMPL_VAL    8'hff
// Device control register and its reload bit
`define HRSP_DEVCTL_ADDR   8'h3f
`define HRSP_RELOAD_BIT    6
`define HRSP_DEVCTL_DEF    8'h40
// Voltage-scaling port selection register, one bit per converter
`define HRSP_VSSEL_ADDR    8'h3e
// Converter voltage-scaling registers: base, stride, count
`define HRSP_VS_BASE       8'h04
`define HRSP_VS_STRIDE     8'h03
`define HRSP_NUM_CONV      4
// Frame bit positions of the serial peripheral port
`define HRSP_SPI_RW_POS    5'h00
`define HRSP_SPI_ADR_END   5'h08
`define HRSP_SPI_DAT_FIRST 5'h10
`define HRSP_SPI_DAT_LAST  5'h17
// Bit index of the acknowledge slot
`define HRSP_ACK_BIT       4'h8

`endif

// ---- include/hrsp_pkg.sv ----
`default_nettype none
package hrsp_pkg;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_DEV  = 3'b001,
		PH_PTR  = 3'b010,
		PH_WR   = 3'b011,
		PH_RD   = 3'b100
	} hrsp_ph_t;
endpackage
`default_nettype wire

// ---- hdl/hrsp_ports.sv ----
// What this block does
// - All ports held in reset outside ACTIVE.
// - Scaling port reaches only voltage-scaling registers.
// - Handed-over registers blocked for general ports.
// - SPI frame: flag, address, seven idle, data.
// - SPI data output released while chip enable low.
// - Standard, fast and high-speed rates supported.
// - Seven-bit addresses only, no general call.
// - General slave address 0101101.
// - Scaling slave address 0010011.
// - Address low bit is factory input.
// - Start condition opens transfer, address follows.
// - Acknowledge address only on match.
// - Direction bit; receiver acknowledges every byte.
// - Stop releases link, await new start.
// - Unimplemented register reads return FFh.
// - Master code switches speed, never acknowledged.
// - Repeated start keeps high speed; stop ends.
// - Oscillator request raised on bus activity.
// - Defaults at supply rise; reload bit on turn-off.
// - Port select pin picks SPI or I2C.
`include "hrsp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hrsp_i2c_slave #(
	parameter logic [5:0] ADR_HI = `HRSP_GEN_ADR_HI
) (
	// System
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       en,
	input  wire logic       adr_lsb,
	// Bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o_q,
	output logic            sda_oe_q,
	// Register access
	output logic [7:0]      ptr_q,
	output logic            wr_q,
	output logic [7:0]      wdata_q,
	input  wire logic [7:0] rdata,
	output logic            hs_q,
	output logic            busy_q
);
	logic            scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic [3:0]      bit_q;
	logic [7:0]      shift_q;
	logic [7:0]      tx_q;
	hrsp_pkg::hrsp_ph_t ph_q;
	logic            rise, fall, start, stop;

	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
		end
	end

	assign rise  = scl_s & ~scl_d;
	assign fall  = ~scl_s & scl_d;
	assign start = scl_s & scl_d & sda_d & ~sda_s;
	assign stop  = scl_s & scl_d & ~sda_d & sda_s;

	// Only ever pulls low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sda_o_q <= 1'b0;
		else
			sda_o_q <= 1'b0;
	end

	// Bus activity flags the oscillator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			busy_q <= 1'b0;
		else
			busy_q <= en & (start | (ph_q != hrsp_pkg::PH_IDLE));
	end

	// Byte engine; sampling only, SCL is never held
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q     <= hrsp_pkg::PH_IDLE;
			bit_q    <= 4'h0;
			shift_q  <= 8'h00;
			tx_q     <= 8'h00;
			sda_oe_q <= 1'b0;
			ptr_q    <= 8'h00;
			wr_q     <= 1'b0;
			wdata_q  <= 8'h00;
			hs_q     <= 1'b0;
		end else if (!en) begin
			ph_q     <= hrsp_pkg::PH_IDLE;
			bit_q    <= 4'h0;
			sda_oe_q <= 1'b0;
			wr_q     <= 1'b0;
			hs_q     <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (start) begin
				ph_q     <= hrsp_pkg::PH_DEV;
				// Wraps to zero on the SCL fall that closes the start
				bit_q    <= 4'hf;
				sda_oe_q <= 1'b0;
			end else if (stop) begin
				ph_q     <= hrsp_pkg::PH_IDLE;
				sda_oe_q <= 1'b0;
				hs_q     <= 1'b0;
			end else if (rise && ph_q != hrsp_pkg::PH_IDLE) begin
				if (bit_q != `HRSP_ACK_BIT)
					shift_q <= {shift_q[6:0], sda_s};
				else if (ph_q == hrsp_pkg::PH_RD && sda_s)
					ph_q <= hrsp_pkg::PH_IDLE;
			end else if (fall && ph_q != hrsp_pkg::PH_IDLE) begin
				if (bit_q == 4'h7) begin
					bit_q <= `HRSP_ACK_BIT;
					case (ph_q)
						hrsp_pkg::PH_DEV: begin
							if (shift_q[7:3] == `HRSP_HS_CODE) begin
								ph_q     <= hrsp_pkg::PH_IDLE;
								sda_oe_q <= 1'b0;
								hs_q     <= 1'b1;
							end else if (shift_q[7:1] == {ADR_HI, adr_lsb}) begin
								sda_oe_q <= 1'b1;
							end else begin
								ph_q     <= hrsp_pkg::PH_IDLE;
								sda_oe_q <= 1'b0;
							end
						end
						hrsp_pkg::PH_PTR: begin
							ptr_q    <= shift_q;
							sda_oe_q <= 1'b1;
						end
						hrsp_pkg::PH_WR: begin
							wr_q     <= 1'b1;
							wdata_q  <= shift_q;
							sda_oe_q <= 1'b1;
						end
						hrsp_pkg::PH_RD: begin
							ptr_q    <= ptr_q + 8'h01;
							sda_oe_q <= 1'b0;
						end
						default: sda_oe_q <= 1'b0;
					endcase
				end else if (bit_q == `HRSP_ACK_BIT) begin
					bit_q <= 4'h0;
					case (ph_q)
						hrsp_pkg::PH_DEV: begin
							if (shift_q[0]) begin
								ph_q     <= hrsp_pkg::PH_RD;
								tx_q     <= {rdata[6:0], 1'b0};
								sda_oe_q <= ~rdata[7];
							end else begin
								ph_q     <= hrsp_pkg::PH_PTR;
								sda_oe_q <= 1'b0;
							end
						end
						hrsp_pkg::PH_PTR: begin
							ph_q     <= hrsp_pkg::PH_WR;
							sda_oe_q <= 1'b0;
						end
						hrsp_pkg::PH_WR: begin
							ptr_q    <= ptr_q + 8'h01;
							sda_oe_q <= 1'b0;
						end
						hrsp_pkg::PH_RD: begin
							tx_q     <= {rdata[6:0], 1'b0};
							sda_oe_q <= ~rdata[7];
						end
						default: sda_oe_q <= 1'b0;
					endcase
				end else begin
					bit_q <= bit_q + 4'h1;
					if (ph_q == hrsp_pkg::PH_RD) begin
						sda_oe_q <= ~tx_q[7];
						tx_q     <= {tx_q[6:0], 1'b0};
					end else begin
						sda_oe_q <= 1'b0;
					end
				end
			end
		end
	end

	property p_start_dev;
		@(posedge clk) disable iff (!rst_n)
		(en && start) |=> (ph_q == hrsp_pkg::PH_DEV && bit_q == 4'hf && !sda_oe_q);
	endproperty
	a_start_dev: assert property (p_start_dev) else $error("start not followed by address phase");

	property p_ack_match;
		@(posedge clk) disable iff (!rst_n)
		(ph_q == hrsp_pkg::PH_DEV && bit_q == `HRSP_ACK_BIT && sda_oe_q) |-> (shift_q[7:1] == {ADR_HI, adr_lsb});
	endproperty
	a_ack_match: assert property (p_ack_match) else $error("address acknowledged without match");

	property p_hs_noack;
		@(posedge clk) disable iff (!rst_n)
		(en && fall && ph_q == hrsp_pkg::PH_DEV && bit_q == 4'h7 && shift_q[7:3] == `HRSP_HS_CODE)
			|=> (!sda_oe_q && hs_q) [*2];
	endproperty
	a_hs_noack: assert property (p_hs_noack) else $error("master code acknowledged or speed not switched");

	property p_stop_release;
		@(posedge clk) disable iff (!rst_n)
		(en && stop && !start) |=> (ph_q == hrsp_pkg::PH_IDLE && !sda_oe_q && !hs_q);
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("stop did not release the link");

	property p_off_quiet;
		@(posedge clk) disable iff (!rst_n)
		!en |=> (!sda_oe_q && !wr_q && ph_q == hrsp_pkg::PH_IDLE);
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("port active outside ACTIVE");
endmodule // hrsp_i2c_slave

module hrsp_ports #(
	parameter logic [8:0] REG_COUNT = 9'h040
) (
	// System
	input  wire logic clk,
	input  wire logic arst_n,
	// Device state and straps
	input  wire logic active,
	input  wire logic supply_ok,
	input  wire logic host_port_select,
	input  wire logic gen_adr_lsb,
	input  wire logic vs_adr_lsb,
	// General I2C
	input  wire logic gen_scl_i,
	input  wire logic gen_sda_i,
	output logic      gen_sda_o,
	output logic      gen_sda_oe,
	// Voltage-scaling I2C
	input  wire logic vs_scl_i,
	input  wire logic vs_sda_i,
	output logic      vs_sda_o,
	output logic      vs_sda_oe,
	// SPI, on its own clock
	input  wire logic spi_clk,
	input  wire logic spi_ce,
	input  wire logic spi_mosi,
	output logic      spi_miso_q,
	output logic      spi_miso_oe_q,
	// Oscillator request
	output logic      osc_run_q
);
	logic       rs_m, rst_n;
	logic [4:0] pin_m, pin_s;
	logic       active_s, sel_s, supply_s, active_d, en_spi_q;
	logic [7:0] regs_q [256];
	logic [7:0] gen_ptr, gen_wdata, gen_rdata, vs_ptr, vs_wdata, vs_rdata;
	logic       gen_wr, vs_wr, gen_busy, vs_busy;
	logic [3:0] vs_sel;
	// SPI side
	logic       frm_n, spi_en_m, spi_en_s;
	logic [4:0] cnt_q;
	logic       rw_q;
	logic [7:0] sh_q, adr_q, rd_adr_q, wr_adr_q, wr_dat_q;
	logic [6:0] tx_q;
	logic       rd_tgl_q, wr_tgl_q;
	// Handshake receive side
	logic [2:0] rd_sy_q, wr_sy_q;
	logic [7:0] spi_rdata_q;

	function automatic logic [2:0] vs_map(input logic [7:0] a);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < `HRSP_NUM_CONV; i++) begin
			if (a == 8'(`HRSP_VS_BASE + `HRSP_VS_STRIDE * i) || a == 8'(`HRSP_VS_BASE + `HRSP_VS_STRIDE * i + 1))
				r = {1'b1, 2'(i)};
		end
		return r;
	endfunction

	function automatic logic allow(input logic [7:0] a, input logic vs_port, input logic [3:0] sel);
		logic [2:0] m;
		m = vs_map(a);
		if (vs_port)
			return m[2] & sel[m[1:0]];
		return ~(m[2] & sel[m[1:0]]) & ({1'b0, a} < REG_COUNT);
	endfunction

	function automatic logic [7:0] def_val(input logic [7:0] a);
		return (a == `HRSP_DEVCTL_ADDR) ? `HRSP_DEVCTL_DEF : 8'h00;
	endfunction

	// Reset release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			{rs_m, rst_n} <= 2'h0;
		else
			{rs_m, rst_n} <= {1'b1, rs_m};
	end

	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_m <= 5'h00;
			pin_s <= 5'h00;
		end else begin
			pin_m <= {active, host_port_select, supply_ok, gen_adr_lsb, vs_adr_lsb};
			pin_s <= pin_m;
		end
	end
	assign active_s = pin_s[4];
	assign sel_s    = pin_s[3];
	assign supply_s = pin_s[2];
	assign vs_sel   = regs_q[`HRSP_VSSEL_ADDR][3:0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_d  <= 1'b0;
			en_spi_q  <= 1'b0;
			osc_run_q <= 1'b0;
		end else begin
			active_d  <= active_s;
			en_spi_q  <= active_s & ~sel_s;
			osc_run_q <= gen_busy | vs_busy;
		end
	end

	assign gen_rdata = allow(gen_ptr, 1'b0, vs_sel) ? regs_q[gen_ptr] : `HRSP_UNIMPL_VAL;
	assign vs_rdata  = allow(vs_ptr, 1'b1, vs_sel) ? regs_q[vs_ptr] : `HRSP_UNIMPL_VAL;

	hrsp_i2c_slave #(.ADR_HI(`HRSP_GEN_ADR_HI)) u_gen (
		.clk     (clk),
		.rst_n   (rst_n),
		.en      (active_s & sel_s),
		.adr_lsb (pin_s[1]),
		.scl_i   (gen_scl_i),
		.sda_i   (gen_sda_i),
		.sda_o_q (gen_sda_o),
		.sda_oe_q(gen_sda_oe),
		.ptr_q   (gen_ptr),
		.wr_q    (gen_wr),
		.wdata_q (gen_wdata),
		.rdata   (gen_rdata),
		.hs_q    (),
		.busy_q  (gen_busy)
	);

	hrsp_i2c_slave #(.ADR_HI(`HRSP_VS_ADR_HI)) u_vs (
		.clk     (clk),
		.rst_n   (rst_n),
		.en      (active_s),
		.adr_lsb (pin_s[0]),
		.scl_i   (vs_scl_i),
		.sda_i   (vs_sda_i),
		.sda_o_q (vs_sda_o),
		.sda_oe_q(vs_sda_oe),
		.ptr_q   (vs_ptr),
		.wr_q    (vs_wr),
		.wdata_q (vs_wdata),
		.rdata   (vs_rdata),
		.hs_q    (),
		.busy_q  (vs_busy)
	);

	// SPI frame logic, cleared while chip enable is low
	assign frm_n = spi_ce & arst_n;

	always_ff @(posedge spi_clk or negedge frm_n) begin
		if (!frm_n)
			{spi_en_m, spi_en_s} <= 2'h0;
		else
			{spi_en_m, spi_en_s} <= {en_spi_q, spi_en_m};
	end

	always_ff @(posedge spi_clk or negedge frm_n) begin
		if (!frm_n) begin
			cnt_q <= 5'h00;
			rw_q  <= 1'b0;
			sh_q  <= 8'h00;
			adr_q <= 8'h00;
		end else begin
			sh_q  <= {sh_q[6:0], spi_mosi};
			cnt_q <= (cnt_q == `HRSP_SPI_DAT_LAST) ? `HRSP_SPI_DAT_FIRST : cnt_q + 5'h01;
			if (cnt_q == `HRSP_SPI_RW_POS)
				rw_q <= spi_mosi;
			if (cnt_q == `HRSP_SPI_ADR_END)
				adr_q <= {sh_q[6:0], spi_mosi};
			else if (cnt_q == `HRSP_SPI_DAT_LAST)
				adr_q <= adr_q + 8'h01;
		end
	end

	// Requests toward the system clock; toggles survive chip enable
	always_ff @(posedge spi_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_tgl_q <= 1'b0;
			wr_tgl_q <= 1'b0;
			rd_adr_q <= 8'h00;
			wr_adr_q <= 8'h00;
			wr_dat_q <= 8'h00;
		end else if (spi_ce) begin
			if (rw_q && cnt_q == `HRSP_SPI_DAT_FIRST) begin
				rd_adr_q <= adr_q + 8'h01;
				rd_tgl_q <= ~rd_tgl_q;
			end else if (cnt_q == `HRSP_SPI_ADR_END) begin
				rd_adr_q <= {sh_q[6:0], spi_mosi};
				rd_tgl_q <= ~rd_tgl_q;
			end
			if (!rw_q && cnt_q == `HRSP_SPI_DAT_LAST) begin
				wr_adr_q <= adr_q;
				wr_dat_q <= {sh_q[6:0], spi_mosi};
				wr_tgl_q <= ~wr_tgl_q;
			end
		end
	end

	// Read data out, MSB first, changed on falling edge
	always_ff @(negedge spi_clk or negedge frm_n) begin
		if (!frm_n) begin
			spi_miso_q    <= 1'b0;
			spi_miso_oe_q <= 1'b0;
			tx_q          <= 7'h00;
		end else if (spi_en_s && rw_q && cnt_q >= `HRSP_SPI_DAT_FIRST) begin
			spi_miso_oe_q <= 1'b1;
			if (cnt_q == `HRSP_SPI_DAT_FIRST) begin
				spi_miso_q <= spi_rdata_q[7];
				tx_q       <= spi_rdata_q[6:0];
			end else begin
				spi_miso_q <= tx_q[6];
				tx_q       <= {tx_q[5:0], 1'b0};
			end
		end else begin
			spi_miso_oe_q <= 1'b0;
		end
	end

	// Toggle synchronisers on the system clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_sy_q <= 3'h0;
			wr_sy_q <= 3'h0;
		end else begin
			rd_sy_q <= {rd_sy_q[1:0], rd_tgl_q};
			wr_sy_q <= {wr_sy_q[1:0], wr_tgl_q};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			spi_rdata_q <= `HRSP_UNIMPL_VAL;
		else if (rd_sy_q[2] != rd_sy_q[1])
			spi_rdata_q <= (en_spi_q && allow(rd_adr_q, 1'b0, vs_sel)) ? regs_q[rd_adr_q] : `HRSP_UNIMPL_VAL;
	end

	// Register set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 256; i++)
				regs_q[i] <= def_val(8'(i));
		end else if (!supply_s || (active_d && !active_s && regs_q[`HRSP_DEVCTL_ADDR][`HRSP_RELOAD_BIT])) begin
			for (int i = 0; i < 256; i++)
				regs_q[i] <= def_val(8'(i));
		end else begin
			if (gen_wr && allow(gen_ptr, 1'b0, vs_sel))
				regs_q[gen_ptr] <= gen_wdata;
			if (vs_wr && allow(vs_ptr, 1'b1, vs_sel))
				regs_q[vs_ptr] <= vs_wdata;
			if (en_spi_q && wr_sy_q[2] != wr_sy_q[1] && allow(wr_adr_q, 1'b0, vs_sel))
				regs_q[wr_adr_q] <= wr_dat_q;
		end
	end

	property p_unimpl_ff;
		@(posedge clk) disable iff (!rst_n)
		({1'b0, gen_ptr} >= REG_COUNT) |-> (gen_rdata == 8'hff);
	endproperty
	a_unimpl_ff: assert property (p_unimpl_ff) else $error("unimplemented read not FFh");

	property p_lock_gen;
		@(posedge clk) disable iff (!rst_n)
		(vs_map(gen_ptr) == {1'b1, 2'h0} && vs_sel[0]) |-> (gen_rdata == 8'hff);
	endproperty
	a_lock_gen: assert property (p_lock_gen) else $error("handed-over register visible on general port");

	property p_vs_scope;
		@(posedge clk) disable iff (!rst_n)
		(vs_map(vs_ptr) < 3'h4) |-> (vs_rdata == 8'hff);
	endproperty
	a_vs_scope: assert property (p_vs_scope) else $error("scaling port reached other register");

	property p_reload;
		@(posedge clk) disable iff (!rst_n)
		(active_d && !active_s && regs_q[`HRSP_DEVCTL_ADDR][`HRSP_RELOAD_BIT])
			|=> (regs_q[`HRSP_DEVCTL_ADDR] == 8'h40 && regs_q[`HRSP_VSSEL_ADDR] == 8'h00);
	endproperty
	a_reload: assert property (p_reload) else $error("defaults not reloaded at turn-off");

	property p_miso_hiz;
		@(posedge clk) disable iff (!arst_n)
		(!spi_ce && !$past(spi_ce)) |-> !spi_miso_oe_q;
	endproperty
	a_miso_hiz: assert property (p_miso_hiz) else $error("data output driven without chip enable");
endmodule // hrsp_ports
`default_nettype wire

// ---- verif/hrsp_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module hrsp_i2c_host (
	// Clock and bus
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Quarter bit of 250 ns
	task automatic tick();
		repeat (5) @(posedge clk);
		#2;
	endtask
	// Start or repeated start
	task automatic start();
		sda_low = 1'b0;
		tick();
		scl = 1'b1;
		tick();
		sda_low = 1'b1;
		tick();
		scl = 1'b0;
		tick();
	endtask
	task automatic stop();
		sda_low = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda_low = 1'b0;
		tick();
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda_low = !b;
		tick();
		scl = 1'b1;
		tick();
		s = sda;
		tick();
		scl = 1'b0;
		tick();
	endtask
	// Byte MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ackd);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			r[i] = s;
		end
		bit_io(last, s);
		ackd = !s;
	endtask
endmodule // hrsp_i2c_host

module hrsp_spi_host (
	// Bus
	input  wire logic miso,
	output logic      sck,
	output logic      ce,
	output logic      mosi
);
	initial begin
		sck = 1'b0;
		ce = 1'b0;
		mosi = 1'b0;
	end
	task automatic sbit(input logic b, output logic s);
		mosi = b;
		#7.5;
		sck = 1'b1;
		s = miso;
		#7.5;
		sck = 1'b0;
	endtask
	// Flag, address, seven idle bits, data bytes; clock still outside frames
	task automatic frame(input logic rw, input logic [7:0] a, input logic [15:0] wd, input int n,
		output logic [15:0] rd);
		logic s;
		rd = 16'h0000;
		ce = 1'b1;
		#23.3;
		sbit(rw, s);
		for (int i = 7; i >= 0; i--) sbit(a[i], s);
		#300;
		for (int i = 0; i < 7; i++) sbit(1'b0, s);
		for (int i = 0; i < 8 * n; i++) begin
			// Mid-byte pause leaves room for prefetch and write hand-over
			if (i % 8 == 4) #300;
			sbit(wd[15], s);
			wd = wd << 1;
			rd = {rd[14:0], s};
		end
		#300;
		ce = 1'b0;
		mosi = !mosi;
		#20;
	endtask
endmodule // hrsp_spi_host

`default_nettype wire

// ---- verif/host_register_serial_ports_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_register_serial_ports_tb;
	logic        clk, arst_n, active, supply_ok, sel, gen_lsb, vs_lsb;
	logic        gen_scl, gen_low, vs_scl, vs_low, sck, ce, mosi;
	wire         gen_oe, gen_o, vs_oe, vs_o, miso_q, miso_oe, osc;
	wire         gen_sda, vs_sda, miso;
	int          err_total, samples_checked, cyc;
	logic [7:0]  r;
	logic [15:0] w;
	logic        a;

	assign gen_sda = !(gen_low || (gen_oe && !gen_o));
	assign vs_sda = !(vs_low || (vs_oe && !vs_o));
	// Pull-up level while released
	assign miso = miso_oe ? miso_q : 1'b1;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	hrsp_ports u_dut (.clk(clk), .arst_n(arst_n), .active(active), .supply_ok(supply_ok),
		.host_port_select(sel), .gen_adr_lsb(gen_lsb), .vs_adr_lsb(vs_lsb), .gen_scl_i(gen_scl),
		.gen_sda_i(gen_sda), .gen_sda_o(gen_o), .gen_sda_oe(gen_oe), .vs_scl_i(vs_scl), .vs_sda_i(vs_sda),
		.vs_sda_o(vs_o), .vs_sda_oe(vs_oe), .spi_clk(sck), .spi_ce(ce), .spi_mosi(mosi),
		.spi_miso_q(miso_q), .spi_miso_oe_q(miso_oe), .osc_run_q(osc));
	hrsp_i2c_host u_gen_host (.clk(clk), .sda(gen_sda), .scl(gen_scl), .sda_low(gen_low));
	hrsp_i2c_host u_vs_host (.clk(clk), .sda(vs_sda), .scl(vs_scl), .sda_low(vs_low));
	hrsp_spi_host u_spi_host (.miso(miso), .sck(sck), .ce(ce), .mosi(mosi));

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			check("timeout", 16'h0, 16'h1);
			complete_run();
		end
	end
	task automatic wclk(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic ist(input logic vs);
		if (vs) u_vs_host.start();
		else u_gen_host.start();
	endtask
	task automatic isp(input logic vs);
		if (vs) u_vs_host.stop();
		else u_gen_host.stop();
	endtask
	task automatic ib(input logic vs, input logic [7:0] d, input logic last, output logic [7:0] rd, output logic ak);
		if (vs) u_vs_host.xfer(d, last, rd, ak);
		else u_gen_host.xfer(d, last, rd, ak);
	endtask
	task automatic iwr(input logic vs, input logic [7:0] dev, input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic [7:0] t;
		logic a1, a2, a3;
		ist(vs);
		ib(vs, dev, 1'b1, t, a1);
		ib(vs, p, 1'b1, t, a2);
		ib(vs, d, 1'b1, t, a3);
		isp(vs);
		ok = a1 && a2 && a3;
	endtask
	task automatic ird(input logic vs, input logic [7:0] dev, input logic [7:0] p, output logic [7:0] d);
		logic a1;
		ist(vs);
		ib(vs, dev, 1'b1, d, a1);
		ib(vs, p, 1'b1, d, a1);
		ist(vs);
		ib(vs, dev | 8'h01, 1'b1, d, a1);
		ib(vs, 8'hff, 1'b1, d, a1);
		isp(vs);
	endtask

	task automatic t_gen();
		logic [7:0] devs [6] = '{8'h00, 8'hf0, 8'h26, 8'h58, 8'h5a, 8'h58};
		logic [5:0] lo = 6'b110000;
		logic [5:0] acks = 6'b100000;
		iwr(1'b0, 8'h5a, 8'h10, 8'h11, a);
		check("ack while inactive", 16'h0, 16'(a));
		active = 1'b1;
		wclk(10);
		ist(1'b0);
		ib(1'b0, 8'h5a, 1'b1, r, a);
		check("address ack", 16'h1, 16'(a));
		ib(1'b0, 8'h10, 1'b1, r, a);
		ib(1'b0, 8'ha5, 1'b1, r, a);
		check("oscillator request", 16'h1, 16'(osc));
		ib(1'b0, 8'h3c, 1'b1, r, a);
		check("data ack", 16'h1, 16'(a));
		isp(1'b0);
		wclk(10);
		check("oscillator idle", 16'h0, 16'(osc));
		ist(1'b0);
		ib(1'b0, 8'h5a, 1'b1, r, a);
		ib(1'b0, 8'h10, 1'b1, r, a);
		ist(1'b0);
		ib(1'b0, 8'h5b, 1'b1, r, a);
		ib(1'b0, 8'hff, 1'b0, r, a);
		check("burst read 0", 16'h00a5, 16'(r));
		ib(1'b0, 8'hff, 1'b1, r, a);
		check("burst read 1", 16'h003c, 16'(r));
		isp(1'b0);
		for (int i = 0; i < 6; i++) begin
			gen_lsb = !lo[i];
			wclk(10);
			ist(1'b0);
			ib(1'b0, devs[i], 1'b1, r, a);
			isp(1'b0);
			check("address filter", 16'(acks[i]), 16'(a));
		end
		gen_lsb = 1'b1;
		wclk(10);
		ist(1'b0);
		ib(1'b0, 8'h08, 1'b1, r, a);
		check("master code ack", 16'h0, 16'(a));
		ist(1'b0);
		ib(1'b0, 8'h5a, 1'b1, r, a);
		check("high speed ack", 16'h1, 16'(a));
		ib(1'b0, 8'h10, 1'b1, r, a);
		ib(1'b0, 8'h66, 1'b1, r, a);
		isp(1'b0);
		ird(1'b0, 8'h5a, 8'h10, r);
		check("high speed write", 16'h0066, 16'(r));
		iwr(1'b0, 8'h5a, 8'h40, 8'h12, a);
		ird(1'b0, 8'h5a, 8'h40, r);
		check("unimplemented read", 16'h00ff, 16'(r));
	endtask

	task automatic t_vs();
		iwr(1'b1, 8'h26, 8'h04, 8'h55, a);
		check("scaling address ack", 16'h1, 16'(a));
		ird(1'b1, 8'h26, 8'h04, r);
		check("scaling unselected", 16'h00ff, 16'(r));
		iwr(1'b0, 8'h5a, 8'h3e, 8'h01, a);
		iwr(1'b1, 8'h26, 8'h04, 8'h77, a);
		ird(1'b1, 8'h26, 8'h04, r);
		check("scaling selected", 16'h0077, 16'(r));
		ird(1'b0, 8'h5a, 8'h04, r);
		check("general blocked", 16'h00ff, 16'(r));
		ird(1'b1, 8'h26, 8'h10, r);
		check("scaling limited", 16'h00ff, 16'(r));
	endtask

	task automatic t_spi();
		sel = 1'b0;
		wclk(10);
		iwr(1'b0, 8'h5a, 8'h10, 8'h01, a);
		check("general deselected", 16'h0, 16'(a));
		u_spi_host.frame(1'b0, 8'h20, 16'h1234, 2, w);
		u_spi_host.frame(1'b1, 8'h20, 16'h0000, 2, w);
		check("spi burst", 16'h1234, w);
		check("miso released", 16'h0, 16'(miso_oe));
		u_spi_host.frame(1'b1, 8'h10, 16'h0000, 1, w);
		check("spi full set", 16'h0066, w);
		u_spi_host.frame(1'b1, 8'h04, 16'h0000, 1, w);
		check("spi blocked", 16'h00ff, w);
		u_spi_host.frame(1'b1, 8'h50, 16'h0000, 1, w);
		check("spi unimplemented", 16'h00ff, w);
		u_spi_host.frame(1'b1, 8'h3f, 16'h0000, 1, w);
		check("control default", 16'h0040, w);
	endtask

	task automatic t_reload();
		active = 1'b0;
		wclk(10);
		u_spi_host.frame(1'b1, 8'h20, 16'h0000, 1, w);
		check("spi inactive", 16'h00ff, w);
		active = 1'b1;
		wclk(10);
		u_spi_host.frame(1'b1, 8'h20, 16'h0000, 2, w);
		check("reloaded", 16'h0000, w);
		u_spi_host.frame(1'b1, 8'h04, 16'h0000, 1, w);
		check("selection reloaded", 16'h0000, w);
		u_spi_host.frame(1'b0, 8'h3f, 16'h0000, 1, w);
		u_spi_host.frame(1'b0, 8'h21, 16'h5500, 1, w);
		active = 1'b0;
		wclk(10);
		active = 1'b1;
		wclk(10);
		u_spi_host.frame(1'b1, 8'h21, 16'h0000, 1, w);
		check("kept", 16'h0055, w);
		supply_ok = 1'b0;
		wclk(10);
		supply_ok = 1'b1;
		wclk(10);
		u_spi_host.frame(1'b1, 8'h21, 16'h0000, 1, w);
		check("lockout reload", 16'h0000, w);
	endtask

	initial begin
		arst_n = 1'b0;
		active = 1'b0;
		supply_ok = 1'b1;
		sel = 1'b1;
		gen_lsb = 1'b1;
		vs_lsb = 1'b1;
		err_total = 0;
		samples_checked = 0;
		cyc = 0;
		wclk(12);
		arst_n = 1'b1;
		wclk(8);
		t_gen();
		t_vs();
		t_spi();
		t_reload();
		complete_run();
	end
endmodule // host_register_serial_ports_tb

`default_nettype wire
